// ---- hdl/eicm_pkg.sv ----
// Shared constants, register map and bus types for the event intake and channel mapper
package eicm_pkg;
  localparam int NUM_EVENTS = 64;
  localparam int NUM_CHANNELS = 10;
  localparam int NUM_HOSTS = 10;
  localparam int MAP_REGS = 16;
  localparam int HOST_MAP_REGS = 3;
  localparam int ADDR_W = 8;
  localparam int EV_IDX_W = 6;
  localparam int SEL_W = 4;
  localparam int FIELD_W = 8;
  localparam int FIELDS_PER_REG = 4;
  localparam int PRIO_NONE_BIT = 31;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_ENABLE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVENT_EN_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVENT_EN_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HOST_EN_SET = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_HOST_EN_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RAW_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RAW_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ENA_STAT_LOW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ENA_STAT_HIGH = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_EVENT_EN_LOW = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_EVENT_EN_HIGH = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_HOST_EN = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_HOST_MAP = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_PRIO_INDEX = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CHAN_MAP = 8'h80;

  // Values after reset and write masks
  localparam logic [31:0] CHAN_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] CHAN_MAP_WMASK = 32'h0F0F_0F0F;
  localparam logic [HOST_MAP_REGS-1:0][31:0] HOST_MAP_RST =
    {32'h0000_0908, 32'h0706_0504, 32'h0302_0100};
  localparam logic [31:0] HOST_MAP_WMASK0 = 32'h0F0F_0F0F;
  localparam logic [31:0] HOST_MAP_WMASK2 = 32'h0000_0F0F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } eicm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eicm_axi_rsp_t;
endpackage

// ---- hdl/eicm_map_mem.sv ----
// Channel map storage: register array with masked writes and a registered read port
`timescale 1ns/100ps
module eicm_map_mem
  import eicm_pkg::*;
#(
  parameter int DEPTH = MAP_REGS,
  parameter int WIDTH = 32,
  parameter int AW = 4,
  parameter logic [WIDTH-1:0] RESET_WORD = CHAN_MAP_RST
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [WIDTH-1:0] i_wr_mask,
  input wire logic i_rd_en,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data,
  output logic [DEPTH*WIDTH-1:0] o_contents
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= RESET_WORD;
      end
      o_rd_data <= '0;
    end else begin
      if (i_wr_en) begin
        mem_reg[i_wr_addr] <= (mem_reg[i_wr_addr] & ~i_wr_mask) | (i_wr_data & i_wr_mask);
      end
      if (i_rd_en) begin
        o_rd_data <= mem_reg[i_rd_addr];
      end
    end
  end

  // Every entry is also visible at once: the mapper needs all of them each cycle
  for (genvar g = 0; g < DEPTH; g++) begin : g_flat
    assign o_contents[g*WIDTH +: WIDTH] = mem_reg[g];
  end
endmodule // eicm_map_mem

// ---- hdl/eicm_top.sv ----
// Event intake, enables, pending status, channel mapping and host outputs
//
// Overview of operation
// - Events from slow or asynchronous sources are synchronised before use.
// - Intake turns each event into an active-high single-cycle pulse.
// - Writing an event number to the index set register enables that event only.
// - Writing a host number enables that output; if already enabled it retriggers.
// - Global enable gates all host outputs but never overrides a cleared individual enable.
// - Raw pending flag records each event regardless of its enable.
// - Enabled pending equals pending gated by enable; zero while enable is clear.
// - Enabled pending reads as two 32-bit words, bit N is event N.
// - Pending flags are sticky until individually cleared.
// - Ten channels; channel 0 highest priority, channel 9 lowest.
// - A channel is active while any enabled pending event mapped to it is.
// - Channel map registers hold four events each, sixteen registers, software writable.
// - Events 1 and 2 carry shift-count status of core A and core B.
// - Any channel may map to any host output; channel x to host x by default.
// - Per host, lowest active channel then lowest active event gives the index.
// - Hosts 0 and 1 go to both cores' status bits; others go to chip.
// - Writing 1 to bit N of enabled status clears event N pending.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module eicm_top
  import eicm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_parity_error_event,
  input wire logic i_core_a_shift_count_event,
  input wire logic i_core_b_shift_count_event,
  input wire logic i_scratchpad_timeout_event,
  input wire logic [2:0] i_serial_port_events,
  input wire logic [7:0] i_timer_events,
  input wire logic i_capture_event,
  input wire logic [15:0] i_core_software_request,
  input wire logic [31:0] i_external_events,
  input wire eicm_axi_req_t i_axi_req,
  output eicm_axi_rsp_t o_axi_rsp,
  output logic [1:0] o_core_host_irq,
  output logic [7:0] o_chip_host_irq
);
  function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base, input int count);
    logic [ADDR_W-3:0] w;
    logic [ADDR_W-3:0] b;
    w = a[ADDR_W-1:2];
    b = base[ADDR_W-1:2];
    return (w >= b) && (int'(w) < int'(b) + count);
  endfunction

  function automatic logic is_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    return a[ADDR_W-1:2] == base[ADDR_W-1:2];
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [SEL_W-1:0] field_of(input logic [31:0] word, input int slot);
    return word[slot*FIELD_W +: SEL_W];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:2] <= OFS_HOST_EN[ADDR_W-1:2])
      || in_block(a, OFS_HOST_MAP, HOST_MAP_REGS)
      || in_block(a, OFS_PRIO_INDEX, NUM_HOSTS)
      || in_block(a, OFS_CHAN_MAP, MAP_REGS);
  endfunction

  // Event vector assembly
  logic [NUM_EVENTS-1:0] event_in;
  assign event_in = {i_external_events, i_core_software_request, i_capture_event,
                     i_timer_events, i_serial_port_events, i_scratchpad_timeout_event,
                     i_core_b_shift_count_event, i_core_a_shift_count_event,
                     i_parity_error_event};

  // Intake: three stages, a level counts once stages two and three agree
  logic [NUM_EVENTS-1:0] sync1_reg, sync2_reg, sync3_reg, level_reg, level_next;
  logic [NUM_EVENTS-1:0] event_pulse;
  assign level_next = (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
  assign event_pulse = sync2_reg & sync3_reg & ~level_reg;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      level_reg <= '0;
    end else begin
      sync1_reg <= event_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // Bus slave state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, rd_pend_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic [ADDR_W-1:0] wr_addr_reg, rd_addr_reg;
  logic aw_fire, w_fire, b_fire, ar_fire, r_fire, wr_fire;

  assign aw_fire = i_axi_req.awvalid & awready_reg;
  assign w_fire = i_axi_req.wvalid & wready_reg;
  assign b_fire = bvalid_reg & i_axi_req.bready;
  assign ar_fire = i_axi_req.arvalid & arready_reg;
  assign r_fire = rvalid_reg & i_axi_req.rready;
  // Address and data both held, no response outstanding
  assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;

  // Write decode
  logic [31:0] wr_mask, wr_bits;
  logic [EV_IDX_W-1:0] wr_index;
  logic idx_ok, host_idx_ok;
  logic wr_global, wr_ev_set, wr_ev_clr, wr_host_set, wr_host_clr;
  logic wr_stat_lo, wr_stat_hi, wr_host_map, wr_chan_map;
  assign wr_mask = strb_mask(wr_strb_reg);
  assign wr_bits = wr_data_reg & wr_mask;
  assign wr_index = wr_data_reg[EV_IDX_W-1:0];
  assign idx_ok = wr_strb_reg[0];
  assign host_idx_ok = idx_ok && (int'(wr_index) < NUM_HOSTS);
  assign wr_global = wr_fire & is_at(wr_addr_reg, OFS_GLOBAL_ENABLE) & idx_ok;
  assign wr_ev_set = wr_fire & is_at(wr_addr_reg, OFS_EVENT_EN_SET) & idx_ok;
  assign wr_ev_clr = wr_fire & is_at(wr_addr_reg, OFS_EVENT_EN_CLR) & idx_ok;
  assign wr_host_set = wr_fire & is_at(wr_addr_reg, OFS_HOST_EN_SET) & host_idx_ok;
  assign wr_host_clr = wr_fire & is_at(wr_addr_reg, OFS_HOST_EN_CLR) & host_idx_ok;
  assign wr_stat_lo = wr_fire & is_at(wr_addr_reg, OFS_ENA_STAT_LOW);
  assign wr_stat_hi = wr_fire & is_at(wr_addr_reg, OFS_ENA_STAT_HIGH);
  assign wr_host_map = wr_fire & in_block(wr_addr_reg, OFS_HOST_MAP, HOST_MAP_REGS);
  assign wr_chan_map = wr_fire & in_block(wr_addr_reg, OFS_CHAN_MAP, MAP_REGS);

  // Enables and pending status
  logic global_en_reg;
  logic [NUM_EVENTS-1:0] event_en_reg, event_en_next, pend_reg, pend_next;
  logic [NUM_EVENTS-1:0] stat_clear, ena_pend, ev_onehot;
  logic [NUM_HOSTS-1:0] host_en_reg, host_en_next, retrig_reg, retrig_next, host_onehot;

  assign ev_onehot = NUM_EVENTS'(1) << wr_index;
  assign host_onehot = NUM_HOSTS'(1) << wr_index;
  assign event_en_next = (event_en_reg | (wr_ev_set ? ev_onehot : '0))
                       & ~(wr_ev_clr ? ev_onehot : '0);
  assign host_en_next = (host_en_reg | (wr_host_set ? host_onehot : '0))
                      & ~(wr_host_clr ? host_onehot : '0);
  // Re-enabling an enabled host drops its output for one cycle so a new edge is seen
  assign retrig_next = wr_host_set ? (host_onehot & host_en_reg) : '0;
  // Only ones clear; zeros leave flags alone
  assign stat_clear = {wr_stat_hi ? wr_bits : 32'h0000_0000,
                       wr_stat_lo ? wr_bits : 32'h0000_0000};
  // A new pulse beats a clear in the same cycle
  assign pend_next = (pend_reg & ~stat_clear) | event_pulse;
  assign ena_pend = pend_reg & event_en_reg;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      global_en_reg <= 1'b0;
      event_en_reg <= '0;
      host_en_reg <= '0;
      retrig_reg <= '0;
      pend_reg <= '0;
    end else begin
      if (wr_global) begin
        global_en_reg <= wr_data_reg[0];
      end
      event_en_reg <= event_en_next;
      host_en_reg <= host_en_next;
      retrig_reg <= retrig_next;
      pend_reg <= pend_next;
    end
  end

  // Channel map storage
  logic [MAP_REGS*32-1:0] chan_map_flat;
  logic [31:0] chan_map_rd;
  eicm_map_mem #(
    .DEPTH(MAP_REGS),
    .WIDTH(32),
    .AW(4),
    .RESET_WORD(CHAN_MAP_RST)
  ) u_chan_map (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_wr_en(wr_chan_map),
    .i_wr_addr(wr_addr_reg[5:2]),
    .i_wr_data(wr_data_reg),
    .i_wr_mask(wr_mask & CHAN_MAP_WMASK),
    .i_rd_en(ar_fire),
    .i_rd_addr(i_axi_req.araddr[5:2]),
    .o_rd_data(chan_map_rd),
    .o_contents(chan_map_flat)
  );

  logic [SEL_W-1:0] chan_sel [NUM_EVENTS];
  for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_chan_sel
    assign chan_sel[e] = field_of(chan_map_flat[(e/FIELDS_PER_REG)*32 +: 32],
                                  e % FIELDS_PER_REG);
  end

  logic [HOST_MAP_REGS-1:0][31:0] host_map_reg;
  logic [SEL_W-1:0] host_sel [NUM_CHANNELS];
  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_host_sel
    assign host_sel[c] = field_of(host_map_reg[c/FIELDS_PER_REG], c % FIELDS_PER_REG);
  end

  logic [31:0] host_map_wmask;
  assign host_map_wmask = (wr_addr_reg[3:2] == 2'd2) ? HOST_MAP_WMASK2 : HOST_MAP_WMASK0;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      host_map_reg <= HOST_MAP_RST;
    end else if (wr_host_map) begin
      host_map_reg[wr_addr_reg[3:2]] <= (host_map_reg[wr_addr_reg[3:2]] & ~host_map_wmask)
                                      | (wr_bits & host_map_wmask);
    end
  end

  // Channel OR and lowest pending event per channel
  logic [NUM_CHANNELS-1:0] chan_active;
  logic [EV_IDX_W-1:0] chan_first [NUM_CHANNELS];
  always_comb begin
    chan_active = '0;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      chan_first[c] = '0;
    end
    // Walking downward leaves the lowest-numbered event as the winner
    for (int e = NUM_EVENTS - 1; e >= 0; e--) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        if (ena_pend[e] && chan_sel[e] == SEL_W'(c)) begin
          chan_active[c] = 1'b1;
          chan_first[c] = EV_IDX_W'(e);
        end
      end
    end
  end

  // Host selection: lowest active channel wins, then its lowest event
  logic [NUM_HOSTS-1:0] host_hit, irq_next, irq_reg;
  logic [EV_IDX_W-1:0] host_idx [NUM_HOSTS];
  always_comb begin
    for (int h = 0; h < NUM_HOSTS; h++) begin
      host_hit[h] = 1'b0;
      host_idx[h] = '0;
      for (int c = NUM_CHANNELS - 1; c >= 0; c--) begin
        if (chan_active[c] && host_sel[c] == SEL_W'(h)) begin
          host_hit[h] = 1'b1;
          host_idx[h] = chan_first[c];
        end
      end
    end
  end

  assign irq_next = host_hit & host_en_reg & {NUM_HOSTS{global_en_reg}} & ~retrig_reg;

  logic [31:0] prio_reg [NUM_HOSTS];
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_reg <= '0;
      for (int h = 0; h < NUM_HOSTS; h++) begin
        prio_reg[h] <= 32'h8000_0000;
      end
    end else begin
      irq_reg <= irq_next;
      for (int h = 0; h < NUM_HOSTS; h++) begin
        prio_reg[h] <= {~host_hit[h], (31 - EV_IDX_W)'(0), host_idx[h]};
      end
    end
  end

  assign o_core_host_irq = irq_reg[1:0];
  assign o_chip_host_irq = irq_reg[NUM_HOSTS-1:2];

  // Read selection
  logic [31:0] rd_value;
  logic [3:0] prio_sel;
  assign prio_sel = 4'(rd_addr_reg[ADDR_W-1:2] - OFS_PRIO_INDEX[ADDR_W-1:2]);
  assign rd_value =
    is_at(rd_addr_reg, OFS_GLOBAL_ENABLE) ? {31'h0000_0000, global_en_reg} :
    is_at(rd_addr_reg, OFS_RAW_LOW) ? pend_reg[31:0] :
    is_at(rd_addr_reg, OFS_RAW_HIGH) ? pend_reg[63:32] :
    is_at(rd_addr_reg, OFS_ENA_STAT_LOW) ? ena_pend[31:0] :
    is_at(rd_addr_reg, OFS_ENA_STAT_HIGH) ? ena_pend[63:32] :
    is_at(rd_addr_reg, OFS_EVENT_EN_LOW) ? event_en_reg[31:0] :
    is_at(rd_addr_reg, OFS_EVENT_EN_HIGH) ? event_en_reg[63:32] :
    is_at(rd_addr_reg, OFS_HOST_EN) ? {22'h00_0000, host_en_reg} :
    in_block(rd_addr_reg, OFS_HOST_MAP, HOST_MAP_REGS) ? host_map_reg[rd_addr_reg[3:2]] :
    in_block(rd_addr_reg, OFS_PRIO_INDEX, NUM_HOSTS) ? prio_reg[prio_sel] :
    in_block(rd_addr_reg, OFS_CHAN_MAP, MAP_REGS) ? chan_map_rd :
    32'h0000_0000;

  // AXI4-Lite handshakes; one write and one read at a time
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
    end else begin
      if (aw_fire) begin
        awready_reg <= 1'b0;
        wr_addr_reg <= i_axi_req.awaddr;
      end
      if (w_fire) begin
        wready_reg <= 1'b0;
        wr_data_reg <= i_axi_req.wdata;
        wr_strb_reg <= i_axi_req.wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(wr_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_fire) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_reg <= 1'b1;
      rd_pend_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      rd_addr_reg <= '0;
    end else begin
      if (ar_fire) begin
        arready_reg <= 1'b0;
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= i_axi_req.araddr;
      end
      // Extra cycle lets the channel map memory deliver its registered word
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= mapped(rd_addr_reg) ? rd_value : 32'h0000_0000;
        rresp_reg <= mapped(rd_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (r_fire) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign o_axi_rsp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                       bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                       rdata: rdata_reg, rresp: rresp_reg};
endmodule // eicm_top

// ---- bench/eicm_assertions.sv ----
// Assertion checker for the event intake and channel mapper ports
`timescale 1ns/100ps
module eicm_checker
  import eicm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire eicm_axi_req_t i_axi_req,
  input wire eicm_axi_rsp_t o_axi_rsp,
  input wire logic [1:0] o_core_host_irq,
  input wire logic [7:0] o_chip_host_irq
);
  // Shadow of the global enable, updated one edge after a write takes effect, once the write response is first seen
  logic [ADDR_W-1:0] wa_reg;
  logic [31:0] wd_reg;
  logic ws_reg;
  logic bv_reg;
  logic glob_reg;
  wire aw_take = i_axi_req.awvalid && o_axi_rsp.awready;
  wire w_take = i_axi_req.wvalid && o_axi_rsp.wready;
  wire glob_hit = o_axi_rsp.bvalid && !bv_reg && wa_reg == OFS_GLOBAL_ENABLE && ws_reg;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wa_reg <= '0;
      wd_reg <= '0;
      ws_reg <= 1'b0;
      bv_reg <= 1'b0;
      glob_reg <= 1'b0;
    end else begin
      if (aw_take) wa_reg <= i_axi_req.awaddr;
      if (w_take) wd_reg <= i_axi_req.wdata;
      if (w_take) ws_reg <= i_axi_req.wstrb[0];
      bv_reg <= o_axi_rsp.bvalid;
      if (glob_hit) glob_reg <= wd_reg[0];
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  write_latency_a: assert property (
    aw_take && w_take |=> !o_axi_rsp.bvalid ##1 o_axi_rsp.bvalid)
    else $error("write response not on time");
  bresp_hold_a: assert property (
    o_axi_rsp.bvalid && !i_axi_req.bready |=> o_axi_rsp.bvalid && $stable(o_axi_rsp.bresp))
    else $error("write response dropped early");
  read_latency_a: assert property (
    i_axi_req.arvalid && o_axi_rsp.arready |=> !o_axi_rsp.rvalid ##1 o_axi_rsp.rvalid)
    else $error("read data not on time");
  rdata_hold_a: assert property (
    o_axi_rsp.rvalid && !i_axi_req.rready |=> o_axi_rsp.rvalid && $stable(o_axi_rsp.rdata))
    else $error("read data changed before taken");
  write_block_a: assert property (
    o_axi_rsp.bvalid |-> !o_axi_rsp.awready && !o_axi_rsp.wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (
    o_axi_rsp.rvalid |-> !o_axi_rsp.arready)
    else $error("read accepted while data pending");
  global_gate_a: assert property (
    !glob_reg |-> o_core_host_irq == 2'h0 && o_chip_host_irq == 8'h00)
    else $error("host output active with global enable off");
  sticky_irq_a: assert property (
    $fell(o_core_host_irq[0]) || $fell(o_chip_host_irq[0]) |-> $past(o_axi_rsp.bvalid))
    else $error("host output fell without a register write");
endmodule // eicm_checker

bind eicm_top eicm_checker u_checker (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_axi_req(i_axi_req),
  .o_axi_rsp(o_axi_rsp),
  .o_core_host_irq(o_core_host_irq),
  .o_chip_host_irq(o_chip_host_irq)
);

// ---- bench/eicm_event_src.sv ----
// Model of the peripheral event sources: timed active-high requests
`timescale 1ns/100ps
module eicm_event_src (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [63:0] i_fire,
  output logic [63:0] o_events
);
  // Each request stands three cycles, long enough for the two-sample filter
  logic [1:0] cnt_reg [64];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 64; i++) cnt_reg[i] <= 2'h0;
    end else begin
      for (int i = 0; i < 64; i++) begin
        if (i_fire[i]) cnt_reg[i] <= 2'h3;
        else if (cnt_reg[i] != 2'h0) cnt_reg[i] <= cnt_reg[i] - 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 64; i++) o_events[i] = (cnt_reg[i] != 2'h0);
  end
endmodule // eicm_event_src

// ---- bench/eicm_top_tb.sv ----
// Self-checking testbench for the event intake and channel mapper
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module eicm_top_tb
  import eicm_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [63:0] fire = '0;
  logic [63:0] ev;
  eicm_axi_req_t req = '0;
  eicm_axi_rsp_t rsp;
  logic [1:0] core_irq;
  logic [7:0] chip_irq;
  int n_errors = 0;
  int n_compared = 0;

  always #2.5 i_clock = ~i_clock;

  eicm_event_src SRC (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_fire(fire), .o_events(ev));

  eicm_top DUT (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_parity_error_event(ev[0]),
    .i_core_a_shift_count_event(ev[1]),
    .i_core_b_shift_count_event(ev[2]),
    .i_scratchpad_timeout_event(ev[3]),
    .i_serial_port_events(ev[6:4]),
    .i_timer_events(ev[14:7]),
    .i_capture_event(ev[15]),
    .i_core_software_request(ev[31:16]),
    .i_external_events(ev[63:32]),
    .i_axi_req(req),
    .o_axi_rsp(rsp),
    .o_core_host_irq(core_irq),
    .o_chip_host_irq(chip_irq)
  );

  // The master waits for every answer; only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    `CHK(rsp.bresp, er)
    // One idle edge so a following call never re-raises bready in the same step
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    `CHK(rsp.rdata, ed)
    `CHK(rsp.rresp, er)
    @(posedge i_clock);
  endtask

  task automatic t_reset_values;
    rd(OFS_ENA_STAT_LOW, 32'h0000_0000, RESP_OKAY);
    rd(OFS_HOST_MAP, 32'h0302_0100, RESP_OKAY);
    rd(OFS_PRIO_INDEX, 32'h8000_0000, RESP_OKAY);
    rd(8'h70, 32'h0000_0000, RESP_SLVERR);
    wr(8'h70, 32'h0000_0001, RESP_SLVERR);
    `CHK(core_irq, 2'h0)
    $display("test reset_values done");
  endtask

  task automatic t_enable_index;
    wr(OFS_EVENT_EN_SET, 32'h0000_0005, RESP_OKAY);
    wr(OFS_EVENT_EN_SET, 32'h0000_0028, RESP_OKAY);
    wr(OFS_EVENT_EN_SET, 32'h0000_0007, RESP_OKAY);
    wr(OFS_EVENT_EN_CLR, 32'h0000_0007, RESP_OKAY);
    rd(OFS_EVENT_EN_LOW, 32'h0000_0020, RESP_OKAY);
    rd(OFS_EVENT_EN_HIGH, 32'h0000_0100, RESP_OKAY);
    $display("test enable_index done");
  endtask

  task automatic t_pending;
    // Events 1, 3, 17 stay disabled; 5 and 40 are enabled
    @(posedge i_clock);
    fire <= 64'h0000_0100_0002_002A;
    @(posedge i_clock);
    fire <= '0;
    repeat (8) @(posedge i_clock);
    rd(OFS_RAW_LOW, 32'h0002_002A, RESP_OKAY);
    rd(OFS_RAW_HIGH, 32'h0000_0100, RESP_OKAY);
    rd(OFS_ENA_STAT_LOW, 32'h0000_0020, RESP_OKAY);
    rd(OFS_ENA_STAT_HIGH, 32'h0000_0100, RESP_OKAY);
    $display("test pending done");
  endtask

  task automatic t_channels;
    wr(8'h84, 32'h0000_0200, RESP_OKAY);
    rd(8'h84, 32'h0000_0200, RESP_OKAY);
    wr(OFS_HOST_EN_SET, 32'h0000_0000, RESP_OKAY);
    wr(OFS_HOST_EN_SET, 32'h0000_0002, RESP_OKAY);
    repeat (3) @(posedge i_clock);
    `CHK(chip_irq, 8'h00)
    wr(OFS_GLOBAL_ENABLE, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(posedge i_clock);
    `CHK(core_irq, 2'h1)
    `CHK(chip_irq, 8'h01)
    rd(OFS_PRIO_INDEX, 32'h0000_0028, RESP_OKAY);
    rd(8'h48, 32'h0000_0005, RESP_OKAY);
    wr(OFS_HOST_EN_SET, 32'h0000_0002, RESP_OKAY);
    `CHK(chip_irq, 8'h00)
    repeat (3) @(posedge i_clock);
    `CHK(chip_irq, 8'h01)
    // Channel 2 joins host 0: channel order must beat the lower event number
    wr(OFS_HOST_MAP, 32'h0300_0100, RESP_OKAY);
    repeat (3) @(posedge i_clock);
    `CHK(chip_irq, 8'h00)
    `CHK(core_irq, 2'h1)
    rd(OFS_PRIO_INDEX, 32'h0000_0028, RESP_OKAY);
    rd(8'h48, 32'h8000_0000, RESP_OKAY);
    wr(OFS_HOST_MAP, 32'h0302_0100, RESP_OKAY);
    $display("test channels done");
  endtask

  task automatic t_clear;
    wr(OFS_ENA_STAT_LOW, 32'h0000_0000, RESP_OKAY);
    rd(OFS_ENA_STAT_LOW, 32'h0000_0020, RESP_OKAY);
    wr(OFS_ENA_STAT_HIGH, 32'h0000_0100, RESP_OKAY);
    repeat (2) @(posedge i_clock);
    `CHK(core_irq, 2'h0)
    `CHK(chip_irq, 8'h01)
    rd(OFS_RAW_HIGH, 32'h0000_0000, RESP_OKAY);
    wr(OFS_ENA_STAT_LOW, 32'h0000_0020, RESP_OKAY);
    repeat (2) @(posedge i_clock);
    `CHK(chip_irq, 8'h00)
    rd(OFS_RAW_LOW, 32'h0002_000A, RESP_OKAY);
    wr(OFS_HOST_EN_CLR, 32'h0000_0000, RESP_OKAY);
    wr(OFS_HOST_EN_SET, 32'h0000_000C, RESP_OKAY);
    rd(OFS_HOST_EN, 32'h0000_0004, RESP_OKAY);
    $display("test clear done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    t_reset_values;
    t_enable_index;
    t_pending;
    t_channels;
    t_clear;
    end_of_test;
  end

  // Whole run needs under two hundred cycles
  initial begin
    repeat (4000) @(posedge i_clock);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule // eicm_top_tb
